// [pd_pkg.sv]
package pd_pkg;
    // Width of the process data word sent to the master
    localparam int WORD_W = 16;
    // Width of the distance field inside the word
    localparam int DIST_FIELD_W = 14;
    // Width of the two auxiliary bits at the bottom of the word
    localparam int AUX_W = 2;
    // Lowest bit of the distance field
    localparam int DIST_LSB = 2;
    // Width of the format-selection parameter value
    localparam int FMT_W = 8;
    // Width of the parameter index on the configuration port
    localparam int INDEX_W = 16;
    // Index of the format-selection parameter
    localparam logic [INDEX_W-1:0] FORMAT_INDEX = 16'h0053;
    // Format: distance plus both switching-output states
    localparam logic [FMT_W-1:0] FMT_SWITCH = 8'h00;
    // Format: distance plus signal quality code
    localparam logic [FMT_W-1:0] FMT_QUALITY = 8'h04;
    // Factory value of the format-selection parameter
    localparam logic [FMT_W-1:0] FMT_RESET = FMT_SWITCH;
    // Largest distance code, 1 mm per count
    localparam logic [DIST_FIELD_W-1:0] DIST_MAX = 14'h3fff;
    // Reset value of the process data word
    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
endpackage

// [pd_pack_if.sv]
`timescale 1ns/1ns
// Carries the raw inputs to the packer and the packed word back
interface pd_pack_if #(parameter int DIST_W = 16);
    logic [DIST_W-1:0] distance; // Raw measured distance in mm
    logic sw1; // State of the first switching output
    logic sw2; // State of the second switching output
    logic [pd_pkg::AUX_W-1:0] quality; // Signal quality code
    logic [pd_pkg::FMT_W-1:0] fmt; // Active format selection
    logic [pd_pkg::WORD_W-1:0] word; // Packed process data word
    // Side that forms the word
    modport packer (
        input distance,
        input sw1,
        input sw2,
        input quality,
        input fmt,
        output word
    );
    // Side that feeds inputs and takes the word
    modport user (
        output distance,
        output sw1,
        output sw2,
        output quality,
        output fmt,
        input word
    );
endinterface

// [pd_word_packer.sv]
`timescale 1ns/1ns
// Clamps the distance and packs it with the auxiliary bits
module pd_word_packer #(
    parameter int DIST_W = 16
) (
    pd_pack_if.packer pif
);
    // Distance lies beyond what the field can show
    wire over_range;
    // Distance field after clamping
    wire [pd_pkg::DIST_FIELD_W-1:0] dist_field;
    // Auxiliary bits chosen by the format
    wire [pd_pkg::AUX_W-1:0] aux_field;
    // Quality format selected
    wire is_quality;

    // Clamp to full scale instead of wrapping
    assign over_range = pif.distance > DIST_W'(pd_pkg::DIST_MAX);
    assign dist_field = over_range ? pd_pkg::DIST_MAX
                      : pif.distance[pd_pkg::DIST_FIELD_W-1:0];

    // Quality code or switching states in the low bits
    assign is_quality = pif.fmt == pd_pkg::FMT_QUALITY;
    assign aux_field = is_quality ? pif.quality
                     : {pif.sw1, pif.sw2};

    // Distance on top, auxiliary bits at the bottom
    assign pif.word = {dist_field, aux_field};
endmodule

// [distance_process_data_link.sv]
`timescale 1ns/1ns
module distance_process_data_link #(
    parameter int DIST_W = 16
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [DIST_W-1:0] distance_in,
    input wire logic distance_valid,
    input wire logic first_switch_output,
    input wire logic second_switch_output,
    input wire logic [pd_pkg::AUX_W-1:0] signal_quality,
    input wire logic param_write,
    input wire logic [pd_pkg::INDEX_W-1:0] param_index,
    input wire logic [pd_pkg::FMT_W-1:0] param_data,
    input wire logic factory_reset,
    output logic [pd_pkg::WORD_W-1:0] process_data,
    output logic process_data_valid,
    output logic [pd_pkg::FMT_W-1:0] format_select,
    output logic states_in_word,
    output logic format_reject
);
    // Reset synchroniser stages
    logic rst_meta;
    logic rst_sync;
    // Carrier to the packer
    pd_pack_if #(.DIST_W(DIST_W)) pif ();
    // Write addressed to the format parameter
    wire fmt_hit;
    // Written value is a supported format
    wire fmt_ok;
    // Next value of the format parameter
    wire [pd_pkg::FMT_W-1:0] next_format;
    // Next value of the reject pulse
    wire next_reject;
    // Next value of the process data word
    wire [pd_pkg::WORD_W-1:0] next_word;

    // Release reset through two flops
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // Feed the packer from the pins and the format register
    assign pif.distance = distance_in;
    assign pif.sw1 = first_switch_output;
    assign pif.sw2 = second_switch_output;
    assign pif.quality = signal_quality;
    assign pif.fmt = format_select;

    // Combinational packer
    pd_word_packer #(.DIST_W(DIST_W)) packer (
        .pif(pif)
    );

    // Decode the parameter write
    assign fmt_hit = param_write && (param_index == pd_pkg::FORMAT_INDEX);
    assign fmt_ok = (param_data == pd_pkg::FMT_SWITCH)
                 || (param_data == pd_pkg::FMT_QUALITY);
    // Factory reset wins over a write in the same cycle
    assign next_format = factory_reset ? pd_pkg::FMT_RESET
                       : (fmt_hit && fmt_ok) ? param_data
                       : format_select;
    // Unsupported format values are refused and leave the layout alone
    assign next_reject = fmt_hit && !fmt_ok && !factory_reset;
    // Word follows a new measurement and holds otherwise
    assign next_word = distance_valid ? pif.word : process_data;

    // Format parameter and its flags
    always_ff @(posedge sys_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            format_select <= pd_pkg::FMT_RESET;
            states_in_word <= 1'b1;
            format_reject <= 1'b0;
        end else begin
            format_select <= next_format;
            states_in_word <= next_format == pd_pkg::FMT_SWITCH;
            format_reject <= next_reject;
        end
    end

    // Outgoing process data word, read-only to the master
    always_ff @(posedge sys_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            process_data <= pd_pkg::WORD_RESET;
            process_data_valid <= 1'b0;
        end else begin
            process_data <= next_word;
            process_data_valid <= distance_valid;
        end
    end

    // Checks on the outgoing word and the format parameter
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_sync);

    // Word only moves after a measurement
    property p_word_hold;
        !distance_valid |=> $stable(process_data);
    endproperty
    a_word_hold: assert property (p_word_hold)
        else $error("process data changed without a measurement");

    // Accepted write lands in the format register
    property p_fmt_write;
        fmt_hit && fmt_ok && !factory_reset
            |=> format_select == $past(param_data);
    endproperty
    a_fmt_write: assert property (p_fmt_write)
        else $error("format write not taken");

    // Factory reset restores format zero
    property p_factory;
        factory_reset |=> format_select == pd_pkg::FMT_SWITCH;
    endproperty
    a_factory: assert property (p_factory)
        else $error("factory reset did not restore format zero");

    // Format zero carries both switch states
    property p_switch_bits;
        distance_valid && format_select == pd_pkg::FMT_SWITCH
            |=> process_data[pd_pkg::AUX_W-1:0]
                == {$past(first_switch_output), $past(second_switch_output)};
    endproperty
    a_switch_bits: assert property (p_switch_bits)
        else $error("switch states missing from word");

    // Format four carries the quality code
    property p_quality_bits;
        distance_valid && format_select == pd_pkg::FMT_QUALITY
            |=> process_data[pd_pkg::AUX_W-1:0] == $past(signal_quality);
    endproperty
    a_quality_bits: assert property (p_quality_bits)
        else $error("quality code missing from word");

    // Over-range distance is clamped to full scale
    property p_clamp;
        distance_valid && distance_in > DIST_W'(pd_pkg::DIST_MAX)
            |=> process_data[pd_pkg::WORD_W-1:pd_pkg::DIST_LSB]
                == pd_pkg::DIST_MAX;
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("distance not clamped");

    // In-range distance passes in the upper bits unchanged
    property p_dist_pass;
        distance_valid && distance_in <= DIST_W'(pd_pkg::DIST_MAX)
            |=> process_data[pd_pkg::WORD_W-1:pd_pkg::DIST_LSB]
                == $past(distance_in[pd_pkg::DIST_FIELD_W-1:0]);
    endproperty
    a_dist_pass: assert property (p_dist_pass)
        else $error("distance field wrong");

    // Only the two supported formats are ever held
    property p_fmt_legal;
        format_select == pd_pkg::FMT_SWITCH
            || format_select == pd_pkg::FMT_QUALITY;
    endproperty
    a_fmt_legal: assert property (p_fmt_legal)
        else $error("unsupported format held");

    // Refused write leaves the format untouched and flags it
    property p_reject;
        fmt_hit && !fmt_ok && !factory_reset
            |=> format_reject && $stable(format_select);
    endproperty
    a_reject: assert property (p_reject)
        else $error("bad format not refused");

    // Valid pulse follows each taken measurement
    property p_valid_rise;
        distance_valid |=> process_data_valid;
    endproperty
    a_valid_rise: assert property (p_valid_rise)
        else $error("valid pulse missing after a measurement");

    // No valid pulse without a measurement
    property p_valid_idle;
        !distance_valid |=> !process_data_valid;
    endproperty
    a_valid_idle: assert property (p_valid_idle)
        else $error("valid pulse without a measurement");

    // Status flag tracks the held format
    property p_states_flag;
        states_in_word == (format_select == pd_pkg::FMT_SWITCH);
    endproperty
    a_states_flag: assert property (p_states_flag)
        else $error("states flag out of step with format");

    // Factory reset never raises a reject
    property p_factory_wins;
        factory_reset |=> !format_reject;
    endproperty
    a_factory_wins: assert property (p_factory_wins)
        else $error("reject raised during factory reset");

    // Reject only follows a refused write
    property p_reject_cause;
        !(fmt_hit && !fmt_ok) |=> !format_reject;
    endproperty
    a_reject_cause: assert property (p_reject_cause)
        else $error("reject without a refused write");

    // Main scenarios
    c_switch_to_quality: cover property (
        format_select == pd_pkg::FMT_SWITCH
            ##1 format_select == pd_pkg::FMT_QUALITY);
    c_clamp: cover property (
        distance_valid && distance_in > DIST_W'(pd_pkg::DIST_MAX));
    c_reject: cover property (format_reject);
    c_back_to_back: cover property (distance_valid [*3]);
endmodule

// [pd_master_model.sv]
`timescale 1ns/1ns
// Far-side reader: takes each delivered word, never drives the device
module pd_master_model (
    input wire logic sys_clk,
    input wire logic [15:0] word,
    input wire logic word_valid,
    output logic [15:0] seen_word,
    output int seen_count
);
    // One direct reader on the link, no gateway between
    // No parameter path and no stored parameter set here
    // Capture the word on each valid cycle, read only
    always @(posedge sys_clk) begin
        if (word_valid === 1'b1) begin
            seen_word <= word;
            seen_count <= seen_count + 1;
        end
    end
endmodule

// [testbench.sv]
`timescale 1ns/1ns
module testbench;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [15:0] distance_in = 16'h0000;
    logic distance_valid = 1'b0;
    logic first_sw = 1'b0;
    logic second_sw = 1'b0;
    logic [1:0] quality = 2'h0;
    logic param_write = 1'b0;
    logic [15:0] param_index = 16'h0000;
    logic [7:0] param_data = 8'h00;
    logic factory_reset = 1'b0;
    logic [15:0] process_data;
    logic process_data_valid;
    logic [7:0] format_select;
    logic states_in_word;
    logic format_reject;
    logic [15:0] seen_word;
    int seen_count;
    int errors = 0;
    int check_count = 0;
    int seed = 82;
    int fmt = 0; // Format the model believes is active
    int exp_q[$]; // Expected words in delivery order
    int meas_n = 0; // Measurements sent so far
    int r;
    // Free-running clock, 10 ns period
    initial forever #5 sys_clk = ~sys_clk;
    distance_process_data_link #(.DIST_W(16)) dut_u (
        .sys_clk(sys_clk), .arst_n(arst_n), .distance_in(distance_in),
        .distance_valid(distance_valid), .first_switch_output(first_sw),
        .second_switch_output(second_sw), .signal_quality(quality),
        .param_write(param_write), .param_index(param_index),
        .param_data(param_data), .factory_reset(factory_reset),
        .process_data(process_data), .process_data_valid(process_data_valid),
        .format_select(format_select), .states_in_word(states_in_word),
        .format_reject(format_reject));
    pd_master_model master_u (
        .sys_clk(sys_clk), .word(process_data), .word_valid(process_data_valid),
        .seen_word(seen_word), .seen_count(seen_count));
    // Compare a process data word
    task chk_word(input string name, input logic [15:0] exp, logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Compare a status or control value
    task chk_ctl(input string name, input logic [7:0] exp, logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One measurement, answer expected exactly one cycle later
    task meas(input int d, input int a, input int b, input int q);
        int w;
        w = (d > 16383 ? 16383 : d) * 4 + (fmt == 4 ? q : a * 2 + b);
        exp_q.push_back(w);
        meas_n++;
        @(posedge sys_clk);
        distance_in <= d[15:0];
        first_sw <= a[0];
        second_sw <= b[0];
        quality <= q[1:0];
        distance_valid <= 1'b1;
        @(posedge sys_clk);
        distance_valid <= 1'b0;
        #1;
        chk_word("process_data", w[15:0], process_data);
        chk_ctl("data_valid", 8'h01, {7'h00, process_data_valid});
        @(posedge sys_clk);
        #1;
        w = exp_q.pop_front();
        chk_word("master_word", w[15:0], seen_word);
        chk_ctl("valid_drop", 8'h00, {7'h00, process_data_valid});
    endtask
    // Random measurements, full input range
    task rnd_meas(input int n);
        repeat (n) begin
            r = $random(seed);
            meas(r & 32'hffff, (r >> 16) & 1, (r >> 17) & 1, (r >> 18) & 3);
        end
    endtask
    // Parameter write or factory reset, then status check
    task pwr(input int idx, input int v, input int fr, input int ef, int er);
        @(posedge sys_clk);
        param_write <= 1'b1;
        param_index <= idx[15:0];
        param_data <= v[7:0];
        factory_reset <= fr[0];
        @(posedge sys_clk);
        param_write <= 1'b0;
        factory_reset <= 1'b0;
        #1;
        chk_ctl("format_select", ef[7:0], format_select);
        chk_ctl("states_in_word", {7'h00, ef == 0},
                {7'h00, states_in_word});
        chk_ctl("format_reject", er[7:0], {7'h00, format_reject});
        fmt = ef;
    endtask
    // Print counts and verdict, then stop
    task end_sim;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Cut a hang short
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        end_sim;
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        chk_ctl("reset_format", 8'h00, format_select);
        chk_ctl("reset_states", 8'h01, {7'h00, states_in_word});
        chk_word("reset_word", 16'h0000, process_data);
        $display("test reset done");
        meas(0, 0, 0, 0);
        meas(16383, 1, 0, 2);
        meas(16384, 0, 1, 1);
        meas(65535, 1, 1, 3);
        rnd_meas(20);
        $display("test format zero done");
        pwr(83, 4, 0, 4, 0);
        meas(16383, 1, 1, 1);
        meas(70, 0, 0, 2);
        rnd_meas(20);
        $display("test format four done");
        pwr(83, 5, 0, 4, 1);
        pwr(83, 255, 0, 4, 1);
        pwr(84, 0, 0, 4, 0);
        meas(1234, 1, 0, 3);
        pwr(83, 7, 1, 0, 0);
        pwr(83, 4, 0, 4, 0);
        pwr(83, 0, 0, 0, 0);
        rnd_meas(10);
        chk_word("master_count", meas_n[15:0], seen_count[15:0]);
        $display("test parameters done");
        end_sim;
    end
endmodule
